// File: hdl/plcm_pkg.sv
// Purpose: shared constants and types of the pll lock and clock measure block
// Assumes: byte addresses on a plain register port, 32-bit data
// Notes:   all offsets, fields and counts live here only
package plcm_pkg;
    localparam int unsigned AW = 32;
    localparam int unsigned DW = 32;

    localparam logic [AW-1:0] OFF_USB_CTRL = 32'hF001_4000;
    localparam logic [AW-1:0] OFF_AUD_A    = 32'hF001_4004;
    localparam logic [AW-1:0] OFF_AUD_B    = 32'hF001_4008;
    localparam logic [AW-1:0] OFF_INT_ST   = 32'hF001_400C;
    localparam logic [AW-1:0] OFF_INT_MASK = 32'hF001_4010;
    localparam logic [AW-1:0] OFF_WP_MODE  = 32'hF001_4014;
    localparam logic [AW-1:0] OFF_STATUS   = 32'hF001_4018;
    localparam logic [AW-1:0] OFF_MCFR     = 32'hF001_4024;

    // usb phy clock control fields
    localparam int unsigned USB_EN_BIT = 0;
    localparam int unsigned XSEL_LSB   = 4;
    localparam int unsigned LCNT_LSB   = 20;
    localparam int unsigned LCNT_W     = 12;
    // audio pll control a/b fields
    localparam int unsigned AUD_ON_BIT   = 0;
    localparam int unsigned AUD_RST_BIT  = 1;
    localparam int unsigned AUD_PIN_BIT  = 2;
    localparam int unsigned AUD_CORE_BIT = 3;
    localparam int unsigned ND_LSB       = 8;
    localparam int unsigned ND_W         = 7;
    localparam int unsigned QC_LSB       = 16;
    localparam int unsigned QC_W         = 8;
    localparam int unsigned FRAC_LSB     = 0;
    localparam int unsigned FRAC_W       = 22;
    localparam int unsigned PRE_LSB      = 24;
    localparam int unsigned POST_LSB     = 28;
    localparam int unsigned PD_W         = 4;
    // frequency measure register fields
    localparam int unsigned MF_W        = 16;
    localparam int unsigned MF_RDY_BIT  = 16;
    localparam int unsigned MF_RST_BIT  = 20;
    localparam int unsigned MF_COUNTER_SOURCE_SELECT_BIT = 24;
    // interrupt bits, write protect, status
    localparam int unsigned INT_LOCK_BIT = 0;
    localparam int unsigned INT_MEAS_BIT = 1;
    localparam int unsigned WP_EN_BIT    = 0;
    localparam int unsigned ST_LOCK_BIT  = 0;

    localparam logic [2:0] SLOW_DIV_LAST = 3'h7;
    localparam logic [3:0] MEAS_LAST     = 4'hF;
    localparam logic [5:0] MULT_12MHZ    = 6'h28;
    localparam logic [5:0] MULT_16MHZ    = 6'h1E;
    localparam logic [5:0] MULT_24MHZ    = 6'h14;

    typedef struct packed {
        logic [ND_W-1:0]   nd;
        logic [QC_W-1:0]   qc;
        logic [FRAC_W-1:0] frac;
        logic [PD_W-1:0]   pre;
        logic [PD_W-1:0]   post;
        logic              on;
        logic              rst_rel;
        logic              pin_en;
        logic              core_en;
    } plcm_aud_cfg_t;

    typedef enum logic [3:0] {
        S_IDLE  = 4'h1,
        S_ALIGN = 4'h2,
        S_COUNT = 4'h4,
        S_DONE  = 4'h8
    } plcm_meas_st_t;
endpackage

// File: hdl/plcm_edge_sync.sv
// Purpose: two-flop synchroniser with registered rising-edge pulse
// Assumes: input toggles slower than half of clk_i
// Notes:   edge is taken from the second and third flops only
`timescale 1ns/1ps
module plcm_edge_sync (
    input  wire logic clk_i,
    input  wire logic rst_n_i,
    input  wire logic d_i,
    output logic      rise_o
);
    logic s1_r;
    logic s2_r;
    logic s3_r;
    logic rise_nxt;

    always_comb begin
        rise_nxt = s2_r & ~s3_r;
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s1_r   <= 1'b0;
            s2_r   <= 1'b0;
            s3_r   <= 1'b0;
            rise_o <= 1'b0;
        end else begin
            s1_r   <= d_i;
            s2_r   <= s1_r;
            s3_r   <= s2_r;
            rise_o <= rise_nxt;
        end
    end
endmodule

// File: hdl/plcm_top.sv
// Purpose: usb pll lock counter, audio pll dividers, main clock frequency meter
// Assumes: slow clock and oscillators arrive as pins far below 25 MHz
// Notes:   registers on a plain port, read data one cycle after the strobe
// Contract
// - setting usb pll enable clears locked flag and loads lock counter
// - lock counter decrements every eight slow clock periods, stops at zero
// - counter at zero sets locked flag, which can raise an interrupt
// - crystal select picks multiplier 40, 30 or 20 for 12, 16, 24 MHz
// - vco frequency is reference times integer plus one plus fraction/2^22
// - core output clock is vco divided by core post divider plus one
// - pin output clock is vco divided by pre times post divider
// - meter counts selected oscillator cycles over sixteen slow periods
// - valid flag low when invalid, oscillator off, or just restarted
// - writing one to restart bit restarts measuring, zero does nothing; the code also restarts on a write that changes source select
// - source select zero counts rc oscillator, one counts crystal
// - measure register writes ignored while write lock is enabled
//
// Decided for this implementation: strobed register access.
`timescale 1ns/1ps
module plcm_top (
    input  wire logic                    clk_i,
    input  wire logic                    rst_n_i,
    input  wire logic [plcm_pkg::AW-1:0] addr_i,
    input  wire logic [plcm_pkg::DW-1:0] wdata_i,
    input  wire logic                    wr_i,
    input  wire logic                    rd_i,
    input  wire logic                    slow_clk_i,
    input  wire logic                    rc_osc_i,
    input  wire logic                    xtal_osc_i,
    input  wire logic                    audio_vco_i,
    input  wire logic                    rc_osc_on_i,
    input  wire logic                    xtal_osc_on_i,
    output logic [plcm_pkg::DW-1:0]      rdata_o,
    output logic                         irq_o,
    output logic                         usb_pll_en_o,
    output logic [5:0]                   usb_pll_mult_o,
    output logic [plcm_pkg::ND_W:0]      audio_fb_int_o,
    output logic [plcm_pkg::FRAC_W-1:0]  audio_fb_frac_o,
    output logic                         audio_pll_run_o,
    output logic                         audio_core_clk_o,
    output logic                         audio_clock_pin_o
);
    import plcm_pkg::*;

    logic slow_rise, rc_rise, x_rise, vco_rise;

    plcm_edge_sync u_slow (.clk_i(clk_i), .rst_n_i(rst_n_i), .d_i(slow_clk_i),
                           .rise_o(slow_rise));
    plcm_edge_sync u_rc   (.clk_i(clk_i), .rst_n_i(rst_n_i), .d_i(rc_osc_i),
                           .rise_o(rc_rise));
    plcm_edge_sync u_x    (.clk_i(clk_i), .rst_n_i(rst_n_i), .d_i(xtal_osc_i),
                           .rise_o(x_rise));
    plcm_edge_sync u_vco  (.clk_i(clk_i), .rst_n_i(rst_n_i), .d_i(audio_vco_i),
                           .rise_o(vco_rise));

    // register state
    logic                usb_en_r, usb_en_nxt;
    logic [1:0]          xsel_r, xsel_nxt;
    logic [LCNT_W-1:0]   lval_r, lval_nxt;
    plcm_aud_cfg_t       cfg_r, cfg_nxt;
    logic [1:0]          ist_r, ist_nxt;
    logic [1:0]          imask_r, imask_nxt;
    logic                wp_r, wp_nxt;
    logic                counter_source_select_r, counter_source_select_nxt;
    logic [DW-1:0]       rdata_nxt;
    logic                irq_nxt;
    // lock counter state
    logic                locked_r, locked_nxt;
    logic                run_r, run_nxt;
    logic [LCNT_W-1:0]   lcnt_r, lcnt_nxt;
    logic [2:0]          pre_r, pre_nxt;
    // meter state
    plcm_meas_st_t       st_r, st_nxt;
    logic [MF_W-1:0]     mcnt_r, mcnt_nxt;
    logic [MF_W-1:0]     measured_cycle_count_r, measured_cycle_count_nxt;
    logic [3:0]          per_r, per_nxt;
    logic                rdy_r, rdy_nxt;
    // audio dividers and outputs
    logic [QC_W-1:0]     cc_r, cc_nxt;
    logic [2*PD_W-1:0]   pc_r, pc_nxt;
    logic [2*PD_W-1:0]   npin;
    logic [5:0]          mult_nxt;
    logic                core_nxt, pin_nxt;

    logic wr_usb, wr_mcfr, tick, lock_ev, meas_ev, restart, sel_on, osc_rise;

    assign wr_usb   = wr_i && (addr_i == OFF_USB_CTRL);
    assign wr_mcfr  = wr_i && (addr_i == OFF_MCFR) && !wp_r;
    assign tick     = run_r && slow_rise && (pre_r == SLOW_DIV_LAST);
    assign lock_ev  = tick && (lcnt_r == '0);
    assign sel_on   = counter_source_select_r ? xtal_osc_on_i : rc_osc_on_i;
    assign osc_rise = counter_source_select_r ? x_rise : rc_rise;
    // restart on one, source change restarts too
    assign restart  = wr_mcfr && (wdata_i[MF_RST_BIT] || (wdata_i[MF_COUNTER_SOURCE_SELECT_BIT] != counter_source_select_r));
    assign meas_ev  = (st_r == S_COUNT) && slow_rise && (per_r == MEAS_LAST);
    assign npin     = cfg_r.pre * cfg_r.post;

    // register file
    always_comb begin
        usb_en_nxt = usb_en_r;
        xsel_nxt   = xsel_r;
        lval_nxt   = lval_r;
        cfg_nxt    = cfg_r;
        imask_nxt  = imask_r;
        wp_nxt     = wp_r;
        counter_source_select_nxt   = counter_source_select_r;
        ist_nxt    = ist_r;
        rdata_nxt  = '0;
        if (wr_usb) begin
            usb_en_nxt = wdata_i[USB_EN_BIT];
            xsel_nxt   = wdata_i[XSEL_LSB +: 2];
            lval_nxt   = wdata_i[LCNT_LSB +: LCNT_W];
        end
        if (wr_i && addr_i == OFF_AUD_A) begin
            cfg_nxt.on      = wdata_i[AUD_ON_BIT];
            cfg_nxt.rst_rel = wdata_i[AUD_RST_BIT];
            cfg_nxt.pin_en  = wdata_i[AUD_PIN_BIT];
            cfg_nxt.core_en = wdata_i[AUD_CORE_BIT];
            cfg_nxt.nd      = wdata_i[ND_LSB +: ND_W];
            cfg_nxt.qc      = wdata_i[QC_LSB +: QC_W];
        end
        if (wr_i && addr_i == OFF_AUD_B) begin
            cfg_nxt.frac = wdata_i[FRAC_LSB +: FRAC_W];
            cfg_nxt.pre  = wdata_i[PRE_LSB +: PD_W];
            cfg_nxt.post = wdata_i[POST_LSB +: PD_W];
        end
        if (wr_i && addr_i == OFF_INT_MASK) imask_nxt = wdata_i[1:0];
        if (wr_i && addr_i == OFF_WP_MODE) wp_nxt = wdata_i[WP_EN_BIT];
        // write lock blocks the measure register
        if (wr_mcfr) counter_source_select_nxt = wdata_i[MF_COUNTER_SOURCE_SELECT_BIT];
        // clear first, so a same-cycle event wins
        if (wr_i && addr_i == OFF_INT_ST) ist_nxt = ist_r & ~wdata_i[1:0];
        if (lock_ev) ist_nxt[INT_LOCK_BIT] = 1'b1;
        if (meas_ev) ist_nxt[INT_MEAS_BIT] = 1'b1;
        if (rd_i) begin
            unique case (addr_i)
                OFF_USB_CTRL: begin
                    rdata_nxt[USB_EN_BIT]            = usb_en_r;
                    rdata_nxt[XSEL_LSB +: 2]         = xsel_r;
                    rdata_nxt[LCNT_LSB +: LCNT_W]    = lval_r;
                end
                OFF_AUD_A: begin
                    rdata_nxt[AUD_ON_BIT]       = cfg_r.on;
                    rdata_nxt[AUD_RST_BIT]      = cfg_r.rst_rel;
                    rdata_nxt[AUD_PIN_BIT]      = cfg_r.pin_en;
                    rdata_nxt[AUD_CORE_BIT]     = cfg_r.core_en;
                    rdata_nxt[ND_LSB +: ND_W]   = cfg_r.nd;
                    rdata_nxt[QC_LSB +: QC_W]   = cfg_r.qc;
                end
                OFF_AUD_B: begin
                    rdata_nxt[FRAC_LSB +: FRAC_W] = cfg_r.frac;
                    rdata_nxt[PRE_LSB +: PD_W]    = cfg_r.pre;
                    rdata_nxt[POST_LSB +: PD_W]   = cfg_r.post;
                end
                OFF_INT_ST:   rdata_nxt[1:0] = ist_r;
                OFF_INT_MASK: rdata_nxt[1:0] = imask_r;
                OFF_WP_MODE:  rdata_nxt[WP_EN_BIT] = wp_r;
                OFF_STATUS:   rdata_nxt[ST_LOCK_BIT] = locked_r;
                OFF_MCFR: begin
                    rdata_nxt[MF_W-1:0]   = measured_cycle_count_r;
                    rdata_nxt[MF_RDY_BIT] = rdy_r;
                    rdata_nxt[MF_COUNTER_SOURCE_SELECT_BIT] = counter_source_select_r;
                end
                default: rdata_nxt = '0;
            endcase
        end
        irq_nxt = |(ist_nxt & imask_nxt);
    end

    // usb pll lock counter
    always_comb begin
        locked_nxt = locked_r;
        run_nxt    = run_r;
        lcnt_nxt   = lcnt_r;
        pre_nxt    = pre_r;
        if (wr_usb && wdata_i[USB_EN_BIT] && !usb_en_r) begin
            locked_nxt = 1'b0;
            run_nxt    = 1'b1;
            lcnt_nxt   = wdata_i[LCNT_LSB +: LCNT_W];
            pre_nxt    = '0;
        end else if (!usb_en_r) begin
            locked_nxt = 1'b0;
            run_nxt    = 1'b0;
        end else if (run_r && slow_rise) begin
            pre_nxt = pre_r + 3'h1;
            if (tick) begin
                if (lcnt_r == '0) begin
                    locked_nxt = 1'b1;
                    run_nxt    = 1'b0;
                end else begin
                    lcnt_nxt = lcnt_r - 1'b1;
                end
            end
        end
        unique case (xsel_r)
            2'h0:    mult_nxt = MULT_12MHZ;
            2'h1:    mult_nxt = MULT_16MHZ;
            default: mult_nxt = MULT_24MHZ;
        endcase
    end

    // frequency meter
    always_comb begin
        st_nxt    = st_r;
        mcnt_nxt  = mcnt_r;
        measured_cycle_count_nxt = measured_cycle_count_r;
        per_nxt   = per_r;
        rdy_nxt   = rdy_r;
        if (!sel_on) begin
            // no valid count while oscillator is off
            st_nxt  = S_IDLE;
            rdy_nxt = 1'b0;
        end else if (restart) begin
            st_nxt  = S_ALIGN;
            rdy_nxt = 1'b0;
        end else begin
            unique case (st_r)
                S_IDLE:  st_nxt = S_ALIGN;
                // window starts on a slow edge so it is never partial
                S_ALIGN: if (slow_rise) begin
                    st_nxt   = S_COUNT;
                    mcnt_nxt = '0;
                    per_nxt  = '0;
                end
                S_COUNT: begin
                    if (osc_rise) mcnt_nxt = mcnt_r + 1'b1;
                    if (slow_rise) begin
                        per_nxt = per_r + 4'h1;
                        // valid only at full window end
                        if (per_r == MEAS_LAST) begin
                            measured_cycle_count_nxt = mcnt_r;
                            rdy_nxt   = 1'b1;
                            st_nxt    = S_DONE;
                        end
                    end
                end
                S_DONE:  st_nxt = S_DONE;
                default: st_nxt = S_IDLE;
            endcase
        end
    end

    // audio pll post dividers driven by the vco pin
    always_comb begin
        cc_nxt = cc_r;
        pc_nxt = pc_r;
        if (vco_rise) begin
            // divide by core post divider plus one
            cc_nxt = (cc_r >= cfg_r.qc) ? '0 : cc_r + 1'b1;
            pc_nxt = (pc_r + 1'b1 >= npin) ? '0 : pc_r + 1'b1;
        end
        core_nxt = cfg_r.on && cfg_r.rst_rel && cfg_r.core_en
                   && (cc_r <= (cfg_r.qc >> 1));
        pin_nxt  = cfg_r.on && cfg_r.rst_rel && cfg_r.pin_en && (npin != '0)
                   && (pc_r < (npin >> 1));
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            usb_en_r <= 1'b0;
            xsel_r   <= '0;
            lval_r   <= '0;
            cfg_r    <= '0;
            ist_r    <= '0;
            imask_r  <= '0;
            wp_r     <= 1'b0;
            counter_source_select_r   <= 1'b0;
            rdata_o  <= '0;
            irq_o    <= 1'b0;
            locked_r <= 1'b0;
            run_r    <= 1'b0;
            lcnt_r   <= '0;
            pre_r    <= '0;
            st_r     <= S_IDLE;
            mcnt_r   <= '0;
            measured_cycle_count_r  <= '0;
            per_r    <= '0;
            rdy_r    <= 1'b0;
            cc_r     <= '0;
            pc_r     <= '0;
            usb_pll_en_o      <= 1'b0;
            usb_pll_mult_o    <= MULT_12MHZ;
            audio_fb_int_o    <= '0;
            audio_fb_frac_o   <= '0;
            audio_pll_run_o   <= 1'b0;
            audio_core_clk_o  <= 1'b0;
            audio_clock_pin_o <= 1'b0;
        end else begin
            usb_en_r <= usb_en_nxt;
            xsel_r   <= xsel_nxt;
            lval_r   <= lval_nxt;
            cfg_r    <= cfg_nxt;
            ist_r    <= ist_nxt;
            imask_r  <= imask_nxt;
            wp_r     <= wp_nxt;
            counter_source_select_r   <= counter_source_select_nxt;
            rdata_o  <= rdata_nxt;
            irq_o    <= irq_nxt;
            locked_r <= locked_nxt;
            run_r    <= run_nxt;
            lcnt_r   <= lcnt_nxt;
            pre_r    <= pre_nxt;
            st_r     <= st_nxt;
            mcnt_r   <= mcnt_nxt;
            measured_cycle_count_r  <= measured_cycle_count_nxt;
            per_r    <= per_nxt;
            rdy_r    <= rdy_nxt;
            cc_r     <= cc_nxt;
            pc_r     <= pc_nxt;
            usb_pll_en_o   <= usb_en_r;
            usb_pll_mult_o <= mult_nxt;
            // feedback word: integer plus one, fraction over 2^22
            audio_fb_int_o    <= {1'b0, cfg_r.nd} + 1'b1;
            audio_fb_frac_o   <= cfg_r.frac;
            audio_pll_run_o   <= cfg_r.on && cfg_r.rst_rel;
            audio_core_clk_o  <= core_nxt;
            audio_clock_pin_o <= pin_nxt;
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    lock_load_a: assert property (wr_usb && wdata_i[USB_EN_BIT] && !usb_en_r
        |=> !locked_r && lcnt_r == $past(wdata_i[LCNT_LSB +: LCNT_W]))
        else $error("lock counter not loaded on enable");
    lock_step_a: assert property (tick && usb_en_r && lcnt_r != '0
        |=> lcnt_r == $past(lcnt_r) - 1'b1)
        else $error("lock counter step wrong");
    lock_flag_a: assert property (usb_en_r && lock_ev
        |=> locked_r && ist_r[INT_LOCK_BIT])
        else $error("lock flag not set at zero");
    mult_map_a: assert property (xsel_r == 2'h1 |=> usb_pll_mult_o == 6'h1E)
        else $error("multiplier mismatch");
    fb_word_a: assert property (rst_n_i |=> audio_fb_int_o == {1'b0, $past(cfg_r.nd)} + 1'b1)
        else $error("feedback integer wrong");
    core_wrap_a: assert property (vco_rise && cc_r == cfg_r.qc |=> cc_r == '0)
        else $error("core divider wrap wrong");
    pin_wrap_a: assert property (vco_rise && npin != '0 && pc_r == npin - 1'b1
        |=> pc_r == '0)
        else $error("pin divider wrap wrong");
    meas_win_a: assert property ($rose(rdy_r)
        |-> $past(st_r == S_COUNT && per_r == MEAS_LAST && slow_rise))
        else $error("valid set outside full window");
    meas_off_a: assert property (!sel_on |=> !rdy_r)
        else $error("valid while oscillator off");
    restart_clr_a: assert property (restart |=> !rdy_r ##1 st_r != S_DONE)
        else $error("restart did not clear valid");
    wp_hold_a: assert property (wr_i && addr_i == OFF_MCFR && wp_r
        |=> $stable(counter_source_select_r))
        else $error("write lock ignored");
    measured_cycle_count_load_a: assert property (meas_ev && sel_on && !restart
        |=> measured_cycle_count_r == $past(mcnt_r) && rdy_r)
        else $error("count not captured");

    lock_done_c: cover property (lock_ev);
    meas_done_c: cover property ($rose(rdy_r));
    restart_c:   cover property (st_r == S_DONE && restart);
endmodule

// File: test/plcm_osc_model.sv
// Purpose: oscillators beside the clock block: slow clock, rc, crystal, audio vco
// Assumes: half periods in ns, well below half the 50 MHz sampling rate
// Notes:   a disabled oscillator rests low, as a gated pad would
`timescale 1ns/1ps
module plcm_osc_model #(
    parameter int SLOW_HALF = 200,
    parameter int RC_HALF   = 50,
    parameter int XTAL_HALF = 100,
    parameter int VCO_HALF  = 60
) (
    input  wire logic rc_on_i,
    input  wire logic xtal_on_i,
    output logic      slow_clk_o,
    output logic      rc_osc_o,
    output logic      xtal_osc_o,
    output logic      audio_vco_o
);
    initial begin
        slow_clk_o = 1'b0;
        rc_osc_o = 1'b0;
        xtal_osc_o = 1'b0;
        audio_vco_o = 1'b0;
    end
    always #SLOW_HALF slow_clk_o = ~slow_clk_o;
    always #RC_HALF rc_osc_o = rc_on_i ? ~rc_osc_o : 1'b0;
    always #XTAL_HALF xtal_osc_o = xtal_on_i ? ~xtal_osc_o : 1'b0;
    always #VCO_HALF audio_vco_o = ~audio_vco_o;
endmodule

// File: test/testbench.sv
// Purpose: register-level test of the pll lock and clock measure block
// Assumes: slow period 400 ns, rc 100 ns, crystal 200 ns, vco 120 ns
// Notes:   counts of sampled clocks are allowed one edge of slack
`timescale 1ns/1ps
module testbench;
    import plcm_pkg::*;
    logic              clk_i, rst_n_i, wr_i, rd_i, rc_on, xt_on;
    logic              slow, rc, xt, vco, irq, usb_en, run, core_clk, pin_clk;
    logic [AW-1:0]     addr_i;
    logic [DW-1:0]     wdata_i, rdata, q;
    logic [5:0]        mult;
    logic [ND_W:0]     fb_int;
    logic [FRAC_W-1:0] fb_frac;
    int                failures = 0, n_checks = 0, cyc = 0, t0, nc = 0, np = 0;

    plcm_osc_model i_plcm_osc_model (.rc_on_i(rc_on), .xtal_on_i(xt_on), .slow_clk_o(slow),
        .rc_osc_o(rc), .xtal_osc_o(xt), .audio_vco_o(vco));
    plcm_top i_plcm_top (.clk_i(clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .slow_clk_i(slow), .rc_osc_i(rc),
        .xtal_osc_i(xt), .audio_vco_i(vco), .rc_osc_on_i(rc_on), .xtal_osc_on_i(xt_on),
        .rdata_o(rdata), .irq_o(irq), .usb_pll_en_o(usb_en), .usb_pll_mult_o(mult),
        .audio_fb_int_o(fb_int), .audio_fb_frac_o(fb_frac), .audio_pll_run_o(run),
        .audio_core_clk_o(core_clk), .audio_clock_pin_o(pin_clk));

    initial begin
        clk_i = 1'b0;
        forever #10 clk_i = ~clk_i;
    end
    always @(posedge core_clk) nc++;
    always @(posedge pin_clk) np++;

    task automatic stop_test();
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (cyc > 20000) begin
            failures++;
            stop_test();
        end
    end

    // exact when lo equals hi, else an inclusive range
    task automatic chk(input logic [DW-1:0] g, lo, hi, input string m);
        n_checks++;
        if (lo === hi ? g !== lo : ($isunknown(g) || g < lo || g > hi)) begin
            failures++;
            $display("BAD %0t %s got %0h", $time, m, g);
        end
    endtask
    task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
        @(posedge clk_i);
        wr_i <= 1'b1;
        addr_i <= a;
        wdata_i <= d;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask
    task automatic rd(input logic [AW-1:0] a);
        @(posedge clk_i);
        rd_i <= 1'b1;
        addr_i <= a;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1 q = rdata;
    endtask
    task automatic settle();
        @(posedge clk_i);
        #1;
    endtask
    // restart, see valid drop, poll it, then reread for a stable count
    task automatic meas(input logic [DW-1:0] d, lo, hi);
        wr(OFF_MCFR, d);
        t0 = cyc;
        rd(OFF_MCFR);
        chk(q[MF_RDY_BIT], 0, 0, "valid after restart");
        do rd(OFF_MCFR); while (q[MF_RDY_BIT] !== 1'b1 && cyc - t0 < 2000);
        chk(cyc - t0, 320, 420, "window length");
        rd(OFF_MCFR);
        chk(q, lo, hi, "measure word");
    endtask

    initial begin
        logic [5:0] mx [3];
        mx = '{6'h28, 6'h1E, 6'h14};
        rst_n_i = 1'b0;
        {wr_i, rd_i, rc_on, xt_on} = 4'h0;
        addr_i = '0;
        wdata_i = '0;
        repeat (6) @(posedge clk_i);
        rst_n_i <= 1'b1;
        #1 chk(mult, 40, 40, "reset multiplier");
        rd(OFF_MCFR);
        chk(q, 0, 0, "meter idle");
        rd(32'hF001_4020);
        chk(q, 0, 0, "unmapped read");
        for (int i = 0; i < 3; i++) begin
            wr(OFF_USB_CTRL, DW'(i) << XSEL_LSB);
            settle();
            chk(mult, mx[i], mx[i], "multiplier");
        end
        wr(OFF_INT_MASK, 32'h0000_0001);
        wr(OFF_USB_CTRL, (32'h0000_0002 << LCNT_LSB) | 32'h0000_0001);
        t0 = cyc;
        rd(OFF_STATUS);
        chk(q[ST_LOCK_BIT], 0, 0, "locked cleared");
        chk(usb_en, 1, 1, "pll enable out");
        while (irq !== 1'b1 && cyc - t0 < 1000) @(posedge clk_i);
        // three loads times eight slow periods of twenty cycles
        chk(cyc - t0, 440, 520, "lock time");
        rd(OFF_STATUS);
        chk(q[ST_LOCK_BIT], 1, 1, "locked set");
        wr(OFF_INT_ST, 32'h0000_0001);
        settle();
        chk(irq, 0, 0, "irq cleared");
        wr(OFF_USB_CTRL, 32'h0000_0000);
        wr(OFF_USB_CTRL, 32'h0000_0001);
        rd(OFF_STATUS);
        chk(q[ST_LOCK_BIT], 0, 0, "relock clears");
        // disable again before the zero-count lock fires, so irq stays low below
        wr(OFF_USB_CTRL, 32'h0000_0000);
        @(posedge clk_i);
        rc_on <= 1'b1;
        meas(32'h0010_0000, 32'h0001_003F, 32'h0001_0041);
        chk(irq, 0, 0, "masked event");
        rd(OFF_INT_ST);
        chk(q[INT_MEAS_BIT], 1, 1, "measure event");
        @(posedge clk_i);
        xt_on <= 1'b1;
        meas(32'h0100_0000, 32'h0101_001F, 32'h0101_0021);
        wr(OFF_WP_MODE, 32'h0000_0001);
        wr(OFF_MCFR, 32'h0010_0000);
        rd(OFF_MCFR);
        chk(q, 32'h0101_001F, 32'h0101_0021, "locked write");
        wr(OFF_WP_MODE, 32'h0000_0000);
        // same source, restart bit clear: count and valid must stay
        wr(OFF_MCFR, 32'h0100_0000);
        rd(OFF_MCFR);
        chk(q, 32'h0101_001F, 32'h0101_0021, "zero restart kept count");
        // bring-up order: off, release reset, dividers, then enables
        wr(OFF_AUD_A, 32'h0000_0000);
        wr(OFF_AUD_A, 32'h0000_0002);
        wr(OFF_AUD_A, 32'h0003_0902);
        wr(OFF_AUD_B, 32'h212A_AAAA);
        wr(OFF_AUD_A, 32'h0003_090F);
        settle();
        chk(fb_int, 10, 10, "feedback integer");
        chk(fb_frac, 22'h2A_AAAA, 22'h2A_AAAA, "feedback fraction");
        chk(run, 1, 1, "audio pll run");
        repeat (10) @(posedge clk_i);
        {nc, np} = 0;
        repeat (240) @(posedge clk_i);
        chk(nc, 9, 11, "core divide by four");
        chk(np, 19, 21, "pin divide by two");
        stop_test();
    end
endmodule
